// ===== common/mcfc_cfg.svh
// constants of the mode control and failure configuration block
// assumes a single 10 MHz core clock; times are in microseconds
`ifndef MCFC_CFG_SVH
`define MCFC_CFG_SVH

// ***************************************************
// clock and times
// ***************************************************
`define MCFC_CLK_MHZ 10
`define MCFC_RD_TIME_US 10000
`define MCFC_LW_TIME_US 200000
`define MCFC_CFGF_TIME_US 10

// ***************************************************
// frame layout: data[15:8], write flag [7], address [6:0]
// ***************************************************
`define MCFC_WR_BIT 7
`define MCFC_ADDR_MODE 7'h01
`define MCFC_ADDR_HW 7'h0e
`define MCFC_ADDR_STAT 7'h41
`define MCFC_ADDR_WKLVL 7'h42

// ***************************************************
// field positions and mode field values
// ***************************************************
`define MCFC_HW_FCSEL 0
`define MCFC_HW_OVRST 1
`define MCFC_ST_POR 0
`define MCFC_ST_OV 1
`define MCFC_ST_FO 2
`define MCFC_WK_PIN_CONFIG_STATUS_BIT 6
`define MCFC_WK_DEV 7
`define MCFC_MF_NORMAL 3'h0
`define MCFC_MF_SLEEP 3'h1
`define MCFC_MF_STOP 3'h2
`define MCFC_MF_SOFTRST 3'h3

`endif

// ===== common/mcfc_pkg.sv
// types of the mode control and failure configuration block
// assumes nothing beyond the tool's package support
package mcfc_pkg;
    // operating modes, coded 0 to 5 in the listed order
    typedef enum logic [2:0] {
        ST_INIT, ST_NORMAL, ST_STOP, ST_SLEEP, ST_RESTART, ST_FAILSAFE
    } mcfc_state_type;
endpackage

// ===== dv/mcfc_host_model.sv
// host-side model of the interrupt pin strap network
// assumes the bench picks pull-up and noise; runs on the core clock
`timescale 1ns/1ns
`default_nettype none
module mcfc_host_model (
    // clock
    input wire logic core_clk_i,
    // strap choice of the board
    input wire logic pull_up_i,
    input wire logic noisy_i,
    // interrupt pin
    input wire logic int_pd_en_i,
    output logic int_pin_o
);
    // changes every cycle: a floating or bouncing line never settles to a default
    logic toggle_q = 1'b0;

    // free-running pattern for an undriven pin
    always @(posedge core_clk_i) begin
        toggle_q <= ~toggle_q;
    end

    // the board pull-up beats the weak pull-down
    // noise keeps the level from ever being stable
    assign int_pin_o = noisy_i ? toggle_q : (pull_up_i ? 1'b1 : (int_pd_en_i ? 1'b0 : toggle_q));
endmodule
`default_nettype wire

// ===== dv/test_mcfc_mode_ctrl.sv
// self-checking bench of the mode control block with short counts
// assumes the host model above and the shared constants header
`include "mcfc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module test_mcfc_mode_ctrl;
    import mcfc_pkg::*;
    localparam int RD = 20; // short reset delay
    localparam int LW = 200; // short long window
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fv = 1'b0;
    logic [15:0] fr = 16'h0000;
    logic [4:0] evt = 5'h00; // wd fail, overvoltage, can, lin, wk
    logic vlow = 1'b0;
    logic ot = 1'b0;
    logic pull_up = 1'b1;
    logic noisy = 1'b0;
    logic tpn = 1'b1;
    logic trg = 1'b0;
    logic s_up;
    wire int_pin;
    logic [7:0] rd;
    mcfc_state_type mode;
    logic ro, pd, fo, ren, rlp, pin_config_status_bit, dev;
    int errors = 0;
    int checks = 0;

    always #50 core_clk_i = ~core_clk_i;

    mcfc_mode_ctrl #(.RD_CYC(RD), .LW_CYC(LW), .CF_CYC(4)) u_mcfc_mode_ctrl (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .spi_frame_valid_i(fv), .spi_frame_i(fr),
        .spi_rd_data_o(rd), .wd_trigger_i(trg), .wd_fail_i(evt[0]), .ov_detect_i(evt[1]),
        .main_regulator_output_low_i(vlow), .ot_present_i(ot), .can_wake_i(evt[2]), .lin_wake_i(evt[3]),
        .wk_wake_i(evt[4]), .int_pin_i(int_pin), .test_pin_n_i(tpn), .mode_o(mode),
        .reset_out_o(ro), .int_pd_en_o(pd), .fail_out_o(fo), .main_reg_en_o(ren),
        .main_reg_lp_o(rlp), .pin_config_status_o(pin_config_status_bit), .dev_mode_o(dev));

    mcfc_host_model u_mcfc_host_model (.core_clk_i(core_clk_i), .pull_up_i(pull_up),
        .noisy_i(noisy), .int_pd_en_i(pd), .int_pin_o(int_pin));

    // ***************************************************
    // helpers
    // ***************************************************
    // strap one restarts; strap zero fails safe except a first failure under select zero
    function automatic mcfc_state_type wd_mode(input logic up, input logic sel, input int k);
        if (up || (!sel && k == 1)) return ST_RESTART;
        return ST_FAILSAFE;
    endfunction

    // select one fails on the first failure, zero on the second
    function automatic logic fo_exp(input logic sel, input int k);
        return sel || k >= 2;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // one frame, held for exactly one taking edge
    task automatic frame(input logic wr, input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        fv <= 1'b1;
        fr <= {d, wr, a};
        @(posedge core_clk_i);
        fv <= 1'b0;
        #1;
    endtask

    task automatic pulse(input logic [4:0] e);
        @(posedge core_clk_i);
        evt <= e;
        @(posedge core_clk_i);
        evt <= 5'h00;
        #1;
    endtask

    // bounded wait for reset release; a hang ends the run
    task automatic wait_ro();
        int n;
        n = 0;
        while (ro !== 1'b1 && n < 4 * RD) begin
            tick(1);
            n++;
        end
        if (ro !== 1'b1) begin
            errors++;
            conclude();
        end
    endtask

    // power-on reset with a chosen board strap
    task automatic por(input logic up, input logic nz, input logic tp);
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        pull_up <= up;
        noisy <= nz;
        tpn <= tp;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        chk(mode, ST_INIT);
        chk({ro, pd, fo, ren}, 4'h5);
    endtask

    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        void'($urandom(32'h84df33ea));
        // all four failure configurations, two failures each
        for (int c = 0; c < 4; c++) begin
            por(c[1], 1'b0, 1'b1);
            wait_ro();
            chk({pin_config_status_bit, pd}, {c[1], 1'b0});
            frame(1'b0, 7'($urandom), 8'($urandom));
            chk(mode, ST_NORMAL);
            frame(1'b1, `MCFC_ADDR_HW, {7'h00, c[0]});
            frame(1'b0, `MCFC_ADDR_HW, 8'h00);
            chk(rd[0], c[0]);
            frame(1'b0, `MCFC_ADDR_WKLVL, 8'h00);
            chk(rd[6], c[1]);
            for (int k = 1; k <= 2; k++) begin
                pulse(5'h01);
                chk(mode, wd_mode(c[1], c[0], k));
                chk(fo, fo_exp(c[0], k));
                if (wd_mode(c[1], c[0], k) == ST_FAILSAFE) begin
                    chk(ren, 1'b0);
                    if ($urandom_range(1, 0)) begin
                        pulse(5'h04 << $urandom_range(2, 0));
                    end else begin
                        @(posedge core_clk_i);
                        ot <= 1'b1;
                        @(posedge core_clk_i);
                        ot <= 1'b0;
                        tick(2);
                    end
                end
                chk(mode, ST_RESTART);
                tick(1);
                chk(ro, 1'b0);
                wait_ro();
                chk(mode, ST_NORMAL);
                frame(1'b0, `MCFC_ADDR_MODE, 8'h00);
                chk(rd[2:0], `MCFC_MF_NORMAL);
            end
        end
        // low-power modes, then overvoltage with restart enabled
        s_up = 1'($urandom);
        por(s_up, 1'b0, 1'b1);
        wait_ro();
        // a trigger inside the long window keeps init from failing
        @(posedge core_clk_i);
        trg <= 1'b1;
        @(posedge core_clk_i);
        trg <= 1'b0;
        tick(LW + 10);
        chk(mode, ST_INIT);
        frame(1'b0, 7'h00, 8'h00);
        frame(1'b1, `MCFC_ADDR_MODE, {5'h00, `MCFC_MF_STOP});
        chk({mode, ren, rlp}, {ST_STOP, 2'h3});
        frame(1'b1, `MCFC_ADDR_MODE, {5'h00, `MCFC_MF_NORMAL});
        frame(1'b1, `MCFC_ADDR_MODE, {5'h00, `MCFC_MF_SLEEP});
        chk({mode, ren}, {ST_SLEEP, 1'b0});
        pulse(5'h10);
        chk(mode, ST_RESTART);
        wait_ro();
        frame(1'b0, `MCFC_ADDR_MODE, 8'h00);
        chk(rd[2:0], `MCFC_MF_NORMAL);
        frame(1'b1, `MCFC_ADDR_HW, 8'h02);
        pulse(5'h02);
        chk({mode, fo}, {(s_up ? ST_RESTART : ST_FAILSAFE), 1'b1});
        frame(1'b0, `MCFC_ADDR_STAT, 8'h00);
        chk(rd[1], 1'b1);
        // unstable strap, missed trigger, soft reset
        por(1'b1, 1'b1, 1'b1);
        wait_ro();
        chk(pin_config_status_bit, 1'b0);
        for (int n = 0; n < LW + 20 && mode !== ST_RESTART; n++) begin
            tick(1);
        end
        chk(mode, ST_RESTART);
        wait_ro();
        frame(1'b1, `MCFC_ADDR_MODE, {5'h00, `MCFC_MF_SOFTRST});
        chk(mode, ST_INIT);
        // debug strap, relatch while flag set, kept once cleared
        por(1'b1, 1'b0, 1'b0);
        wait_ro();
        chk({dev, pin_config_status_bit}, 2'h3);
        frame(1'b0, 7'h00, 8'h00);
        pulse(5'h01);
        chk(mode, ST_NORMAL);
        for (int r = 0; r < 2; r++) begin
            @(posedge core_clk_i);
            pull_up <= r[0];
            vlow <= 1'b1;
            tick(3);
            chk({mode, pd}, {ST_RESTART, 1'b1 ^ r[0]});
            @(posedge core_clk_i);
            vlow <= 1'b0;
            wait_ro();
            chk(pin_config_status_bit, 1'b0);
            frame(1'b1, `MCFC_ADDR_STAT, 8'h01);
        end
        conclude();
    end
endmodule
`default_nettype wire

// ===== verilog/mcfc_mode_ctrl.sv
// operating-mode state machine with strap-selected failure handling
// assumes rst_i is the power-on reset and all inputs are synchronous
//
// Overview of operation
// - six modes; init at power-up and soft reset
// - stop keeps regulator on; sleep turns off
// - restart holds reset, then normal after delay
// - fail-safe: regulator off until wake or cool
// - debug strap low in init halts watchdog
// - configuration and diagnosis through 16-bit frames
// - host writes mode field; restart clears it
// - power-up enters init; long window starts
// - pull-down, filter, latch strap at reset release
// - power-on flag set re-arms strap latch
// - unstable strap level latches zero
// - strap one: watchdog failure goes restart
// - strap zero: failure goes fail-safe mostly
// - enabled overvoltage flags, fails, picks mode
// - host reads fail-count select and strap
// - latched strap kept until power-on reset once flag cleared
// - any command in init after reset release enters normal
// - missed trigger in init counts as a watchdog failure
`include "mcfc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module mcfc_mode_ctrl #(
    parameter int unsigned RD_CYC = `MCFC_RD_TIME_US * `MCFC_CLK_MHZ,
    parameter int unsigned LW_CYC = `MCFC_LW_TIME_US * `MCFC_CLK_MHZ,
    parameter int unsigned CF_CYC = `MCFC_CFGF_TIME_US * `MCFC_CLK_MHZ
) (
    // clock and power-on reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // decoded serial frames
    input wire logic spi_frame_valid_i,
    input wire logic [15:0] spi_frame_i,
    output logic [7:0] spi_rd_data_o,
    // supervision events
    input wire logic wd_trigger_i,
    input wire logic wd_fail_i,
    input wire logic ov_detect_i,
    input wire logic main_regulator_output_low_i,
    input wire logic ot_present_i,
    // wake sources
    input wire logic can_wake_i,
    input wire logic lin_wake_i,
    input wire logic wk_wake_i,
    // strap pins
    input wire logic int_pin_i,
    input wire logic test_pin_n_i,
    // outputs
    output mcfc_pkg::mcfc_state_type mode_o,
    output logic reset_out_o,
    output logic int_pd_en_o,
    output logic fail_out_o,
    output logic main_reg_en_o,
    output logic main_reg_lp_o,
    output logic pin_config_status_o,
    output logic dev_mode_o
);
    import mcfc_pkg::*;

    // ***************************************************
    // frame decode
    // ***************************************************
    // true when the frame is a write to the given address
    function automatic logic is_wr(input logic [15:0] f, input logic [6:0] a);
        is_wr = f[`MCFC_WR_BIT] && (f[6:0] == a);
    endfunction

    mcfc_state_type state_q, state_d; // current and next mode
    logic [2:0] mode_field_q; // host-written mode field
    logic fcsel_q; // fail-count select
    logic ovrst_q; // overvoltage restart enable
    logic por_q; // power-on flag
    logic ov_flag_q; // overvoltage flag
    logic wd_seen_q; // a watchdog failure already happened
    logic trig_q; // trigger seen in the long window
    logic ot_prev_q; // overtemperature last cycle
    logic rd_done, lw_done, flt_val, flt_stable;

    wire [7:0] wdata = spi_frame_i[15:8];
    wire cmd = spi_frame_valid_i;
    wire wr_mode = cmd && is_wr(spi_frame_i, `MCFC_ADDR_MODE);
    wire wr_hw = cmd && is_wr(spi_frame_i, `MCFC_ADDR_HW);
    wire wr_stat = cmd && is_wr(spi_frame_i, `MCFC_ADDR_STAT);
    wire [2:0] mf_new = wdata[2:0];
    wire reg_on = (state_q != ST_SLEEP) && (state_q != ST_FAILSAFE);
    wire run_mode = (state_q == ST_NORMAL) || (state_q == ST_STOP);
    wire wake = can_wake_i || lin_wake_i || wk_wake_i;

    // ***************************************************
    // timers and strap filter
    // ***************************************************
    // reset delay runs in init or restart while reset is asserted and the supply is up
    wire rd_run = !reset_out_o && !main_regulator_output_low_i &&
                  ((state_q == ST_INIT) || (state_q == ST_RESTART));
    // the long window is halted in the development variant
    wire lw_run = (state_q == ST_INIT) && reset_out_o && !dev_mode_o && !trig_q;
    wire ro_rise = rd_run && rd_done;
    // done lingers one cycle after the window stops; gate it so one miss counts once
    wire lw_exp = lw_run && lw_done;

    mcfc_timer #(.N(RD_CYC)) u_rd_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .run_i(rd_run),
        .done_o(rd_done)
    );
    mcfc_timer #(.N(LW_CYC)) u_lw_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .run_i(lw_run),
        .done_o(lw_done)
    );
    // filter looks at the pin only while the pull-down is on
    mcfc_strap_filter #(.N(CF_CYC)) u_strap_filter (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .en_i(int_pd_en_o),
        .pin_i(int_pin_i),
        .value_o(flt_val),
        .stable_o(flt_stable)
    );

    // ***************************************************
    // failure classification
    // ***************************************************
    wire wd_fail_ev = (wd_fail_i && run_mode && !dev_mode_o) || lw_exp;
    wire ov_ev = ov_detect_i && ovrst_q && reg_on;
    // fail outputs: first failure with select one, else second
    wire wd_fo = fcsel_q || wd_seen_q;
    // strap zero goes fail-safe unless this is the first of two
    wire wd_to_fs = !pin_config_status_o && (fcsel_q || wd_seen_q);
    wire ot_gone = ot_prev_q && !ot_present_i;
    wire sel_lat = ro_rise && por_q;
    wire cfg_new = flt_stable ? flt_val : 1'b0;

    // ***************************************************
    // next mode
    // ***************************************************
    always_comb begin
        state_d = state_q;
        if (ov_ev) begin
            state_d = pin_config_status_o ? ST_RESTART : ST_FAILSAFE;
        end else if (wd_fail_ev) begin
            state_d = wd_to_fs ? ST_FAILSAFE : ST_RESTART;
        end else begin
            case (state_q)
                ST_INIT: begin
                    if (reset_out_o && cmd) begin
                        state_d = ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    if (main_regulator_output_low_i) begin
                        state_d = ST_RESTART;
                    end else if (wr_mode && mf_new == `MCFC_MF_STOP) begin
                        state_d = ST_STOP;
                    end else if (wr_mode && mf_new == `MCFC_MF_SLEEP) begin
                        state_d = ST_SLEEP;
                    end else if (wr_mode && mf_new == `MCFC_MF_SOFTRST) begin
                        state_d = ST_INIT;
                    end
                end
                ST_STOP: begin
                    // stop cannot go straight to sleep; that lands in restart
                    if (main_regulator_output_low_i || (wr_mode && mf_new == `MCFC_MF_SLEEP)) begin
                        state_d = ST_RESTART;
                    end else if (wr_mode && mf_new == `MCFC_MF_NORMAL) begin
                        state_d = ST_NORMAL;
                    end else if (wr_mode && mf_new == `MCFC_MF_SOFTRST) begin
                        state_d = ST_INIT;
                    end
                end
                ST_SLEEP: begin
                    if (wake) begin
                        state_d = ST_RESTART;
                    end
                end
                ST_RESTART: begin
                    if (ro_rise) begin
                        state_d = ST_NORMAL;
                    end
                end
                ST_FAILSAFE: begin
                    if (wake || ot_gone) begin
                        state_d = ST_RESTART;
                    end
                end
                default: state_d = ST_INIT;
            endcase
        end
    end

    // reset asserts on entering any mode that restarts the host
    // init keeps the host released once its delay has run; a soft reset pulls it low
    wire ro_d = (state_d == ST_NORMAL) || (state_d == ST_STOP) ||
                ((state_d == ST_INIT) && (ro_rise || (reset_out_o && state_q == ST_INIT)));

    // ***************************************************
    // mode, outputs and supervision flags
    // ***************************************************
    // state and pin outputs move on the same edge; with the power-on flag clear the pull-down enable follows the previous mode, one cycle late
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= ST_INIT;
            mode_o <= ST_INIT;
            reset_out_o <= 1'b0;
            int_pd_en_o <= 1'b1;
            main_reg_en_o <= 1'b1;
            main_reg_lp_o <= 1'b0;
            ot_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_o <= state_d;
            reset_out_o <= ro_d;
            int_pd_en_o <= !ro_d && (por_q || state_q == ST_INIT);
            main_reg_en_o <= (state_d != ST_SLEEP) && (state_d != ST_FAILSAFE);
            main_reg_lp_o <= (state_d == ST_STOP);
            ot_prev_q <= ot_present_i;
        end
    end

    // host fields; hardware events win over a clear in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode_field_q <= `MCFC_MF_NORMAL;
            fcsel_q <= 1'b0;
            ovrst_q <= 1'b0;
            por_q <= 1'b1;
            ov_flag_q <= 1'b0;
            fail_out_o <= 1'b0;
            wd_seen_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            if (state_q == ST_RESTART) begin
                mode_field_q <= `MCFC_MF_NORMAL;
            end else if (wr_mode) begin
                mode_field_q <= mf_new;
            end
            // hardware control writes only in init or normal mode
            if (wr_hw && (state_q == ST_INIT || state_q == ST_NORMAL)) begin
                fcsel_q <= wdata[`MCFC_HW_FCSEL];
                ovrst_q <= wdata[`MCFC_HW_OVRST];
            end
            if (wr_stat && wdata[`MCFC_ST_POR]) begin
                por_q <= 1'b0;
            end
            ov_flag_q <= ov_ev || (ov_flag_q && !(wr_stat && wdata[`MCFC_ST_OV]));
            fail_out_o <= ov_ev || (wd_fail_ev && wd_fo) ||
                          (fail_out_o && !(wr_stat && wdata[`MCFC_ST_FO]));
            if (wd_fail_ev) begin
                wd_seen_q <= 1'b1;
            end
            trig_q <= (state_q == ST_INIT) && (trig_q || wd_trigger_i);
        end
    end

    // ***************************************************
    // strap latches
    // ***************************************************
    // values change only at a release of reset while the flag is set
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_config_status_o <= 1'b0;
            dev_mode_o <= 1'b0;
        end else if (sel_lat) begin
            pin_config_status_o <= cfg_new;
            if (state_q == ST_INIT) begin
                dev_mode_o <= !test_pin_n_i;
            end
        end
    end

    // ***************************************************
    // readback
    // ***************************************************
    wire [6:0] raddr = spi_frame_i[6:0];
    wire [7:0] rd_d = (raddr == `MCFC_ADDR_HW) ? {6'h00, ovrst_q, fcsel_q} :
                      (raddr == `MCFC_ADDR_WKLVL) ?
                      {dev_mode_o, pin_config_status_o, 6'h00} :
                      (raddr == `MCFC_ADDR_STAT) ?
                      {5'h00, fail_out_o, ov_flag_q, por_q} :
                      (raddr == `MCFC_ADDR_MODE) ? {5'h00, mode_field_q} : 8'h00;

    // answer is loaded for every frame and held until the next
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            spi_rd_data_o <= 8'h00;
        end else if (cmd) begin
            spi_rd_data_o <= rd_d;
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    a_stop_reg_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == ST_STOP |-> main_reg_en_o && main_reg_lp_o)
        else $error("stop mode without regulator on");
    a_failsafe_reg_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == ST_FAILSAFE |-> !main_reg_en_o && !reset_out_o)
        else $error("fail-safe with regulator on");
    a_restart_holds_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == ST_RESTART |-> !reset_out_o ##1 mode_field_q == `MCFC_MF_NORMAL)
        else $error("restart without reset or field clear");
    a_init_cmd_normal: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_q == ST_INIT && reset_out_o && cmd && !ov_ev && !lw_exp
        |=> state_q == ST_NORMAL)
        else $error("command in init did not reach normal");
    a_window_miss: assert property (@(posedge core_clk_i) disable iff (rst_i)
        lw_exp && !ov_ev |=> state_q == ST_RESTART && !reset_out_o)
        else $error("missed trigger did not restart");
    a_unstable_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sel_lat && !flt_stable |=> !pin_config_status_o)
        else $error("unstable strap did not latch zero");
    a_config_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !sel_lat |=> $stable(pin_config_status_o))
        else $error("strap latch changed without release");
    a_first_fail_fo: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wd_fail_ev && fcsel_q |=> fail_out_o)
        else $error("fail output missing on first failure");
    a_strap1_restart: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wd_fail_ev && !ov_ev && pin_config_status_o |=> state_q == ST_RESTART)
        else $error("strap one failure not restart");
    a_strap0_failsafe: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wd_fail_ev && !ov_ev && !pin_config_status_o && wd_seen_q
        |=> state_q == ST_FAILSAFE)
        else $error("strap zero second failure not fail-safe");
    a_ov_reaction: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ov_ev |=> ov_flag_q && fail_out_o &&
        (state_q == (pin_config_status_o ? ST_RESTART : ST_FAILSAFE)))
        else $error("overvoltage reaction wrong");
    a_dev_no_window: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dev_mode_o [*2] |-> !lw_done)
        else $error("window expired in development variant");
endmodule
`default_nettype wire

// ===== verilog/mcfc_strap_filter.sv
// continuous filter on the strap level: stable once unchanged for N cycles
// assumes the sampled pin is synchronous to the clock
`timescale 1ns/1ns
`default_nettype none
module mcfc_strap_filter #(
    parameter int unsigned N = 100,
    parameter int unsigned W = $clog2(N + 1)
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // sampling
    input wire logic en_i,
    input wire logic pin_i,
    output logic value_o,
    output logic stable_o
);
    // ***************************************************
    // filter state
    // ***************************************************
    logic [W-1:0] cnt_q; // cycles the level has held
    logic last_q; // previous sample
    wire changed = (pin_i != last_q);
    assign value_o = last_q;
    assign stable_o = (cnt_q == W'(N));

    // any change restarts the count, so a glitch never looks stable
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !en_i) begin
            cnt_q <= '0;
            last_q <= 1'b0;
        end else begin
            last_q <= pin_i;
            if (changed) begin
                cnt_q <= '0;
            end else if (!stable_o) begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/mcfc_timer.sv
// elapsed-time counter: counts while run is high, restarts when low
// assumes a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module mcfc_timer #(
    parameter int unsigned N = 100,
    parameter int unsigned W = $clog2(N + 1)
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // control and status
    input wire logic run_i,
    output logic done_o
);
    // ***************************************************
    // counter
    // ***************************************************
    logic [W-1:0] cnt_q; // cycles spent running
    assign done_o = (cnt_q == W'(N));

    // saturate at the target so done stays a level
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_i) begin
            cnt_q <= '0;
        end else if (!done_o) begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule
`default_nettype wire
